// ---- rtl/rgsm_pkg.sv ----
// rgsm_pkg: constants, codes and carriers of the general pin one block
// assumes: one 10 MHz clock, register requests from the device port logic
package rgsm_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_PIN_CFG = 8'h40;
  localparam logic [7:0] ADDR_TX_ADJ = 8'h70;
  localparam logic [7:0] RST_PIN_CFG = 8'h00;
  localparam logic [7:0] RST_TX_ADJ = 8'h7c;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_DRV_TYPE = 7;
  localparam int BIT_TRIG_KIND = 6;
  localparam int BIT_DIR = 5;
  localparam int BIT_IN_LEVEL = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 0;
  localparam int TERM_MSB = 7;
  localparam int TERM_LSB = 6;
  localparam int SLEW_MSB = 5;
  localparam int SLEW_LSB = 4;
  localparam int AMP_MSB = 3;
  localparam int AMP_LSB = 0;
  // ************************************************************
  // output source codes
  // ************************************************************
  typedef enum logic [3:0] {
    SRC_REMOTE_WAKE = 4'h0,
    SRC_LSFS_DISC = 4'h1,
    SRC_HS_UNSQUELCH = 4'h2,
    SRC_HS_DISC_SE1 = 4'h3,
    SRC_UNCONFIGURED = 4'h4,
    SRC_HOST_MODE = 4'h5,
    SRC_PERIPH_MODE = 4'h6,
    SRC_CONNECTED = 4'h7,
    SRC_BUS_RESET = 4'h8,
    SRC_L0 = 4'h9,
    SRC_L1 = 4'ha,
    SRC_L2 = 4'hb,
    SRC_HS_TEST = 4'hc,
    SRC_FORCE_HIGH = 4'hd,
    SRC_FORCE_LOW = 4'he,
    SRC_OVERVOLTAGE = 4'hf
  } rgsm_src_e;
  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rgsm_reg_req_s;
  typedef struct packed {
    logic remote_wake;
    logic lsfs_disc;
    logic hs_unsquelch;
    logic hs_disc_se1;
    logic unconfigured;
    logic host_mode;
    logic periph_mode;
    logic connected;
    logic bus_reset;
    logic l0;
    logic l1;
    logic l2;
    logic hs_test;
    logic overvoltage;
  } rgsm_rpt_state_s;
endpackage

// ---- rtl/rgsm_sync2.sv ----
// rgsm_sync2: two-flop synchroniser for one level
// assumes: input is asynchronous to i_ref_clk
`timescale 1ns/1ns
`default_nettype none
module rgsm_sync2 (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_ff;
  logic sync_ff;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end
  assign o_sync = sync_ff;
endmodule // rgsm_sync2
`default_nettype wire

// ---- rtl/rgsm_reg8.sv ----
// rgsm_reg8: 8-bit register with load and reset value
// assumes: load and data come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module rgsm_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ld,
  input wire logic [7:0] i_d,
  output logic [7:0] o_q
);
  logic [7:0] q_ff;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      q_ff <= RST_VAL;
    end else if (i_ld) begin
      q_ff <= i_d;
    end
  end
  assign o_q = q_ff;
endmodule // rgsm_reg8
`default_nettype wire

// ---- rtl/rgsm_top.sv ----
// rgsm_top: general pin one config, source mux and tx adjust register
// assumes: register requests from the device port on i_ref_clk,
// repeater state on i_ref_clk, pin level asynchronous
`timescale 1ns/1ns
`default_nettype none
module rgsm_top #(
  parameter int SEL_W = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire rgsm_pkg::rgsm_reg_req_s i_reg_req,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire rgsm_pkg::rgsm_rpt_state_s i_rpt_state,
  input wire logic i_otp_load,
  input wire logic [7:0] i_otp_tx_adjust,
  input wire logic i_pin_in,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_int_req,
  output logic [1:0] o_hs_termination_code,
  output logic [1:0] o_hs_tx_slew_code,
  output logic [3:0] o_hs_tx_amplitude_code
);
  // ************************************************************
  // parameter check
  // ************************************************************
  if (SEL_W != 4) begin : g_bad_sel_w
    $error("selector must be four bits wide");
  end

  // ************************************************************
  // pin input sampling
  // ************************************************************
  logic pin_level;
  logic pin_level_d_ff;
  rgsm_sync2 u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_async(i_pin_in),
    .o_sync(pin_level)
  );

  // ************************************************************
  // register decode
  // ************************************************************
  wire hit_cfg = i_reg_req.addr == rgsm_pkg::ADDR_PIN_CFG;
  wire hit_tx = i_reg_req.addr == rgsm_pkg::ADDR_TX_ADJ;
  wire wr_cfg = i_reg_req.wr && hit_cfg;
  // factory load wins over a software write
  // load on factory default or on a software write to the tx adjust register
  wire ld_tx = i_otp_load || (i_reg_req.wr && hit_tx);
  wire [7:0] tx_d = i_otp_load ? i_otp_tx_adjust : i_reg_req.wdata;

  logic [7:0] cfg_q;
  logic [7:0] tx_q;
  rgsm_reg8 #(
    .RST_VAL(rgsm_pkg::RST_PIN_CFG)
  ) u_cfg_reg (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_ld(wr_cfg),
    .i_d(i_reg_req.wdata),
    .o_q(cfg_q)
  );
  rgsm_reg8 #(
    .RST_VAL(rgsm_pkg::RST_TX_ADJ)
  ) u_tx_reg (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_ld(ld_tx),
    .i_d(tx_d),
    .o_q(tx_q)
  );

  // ************************************************************
  // config fields
  // ************************************************************
  wire drv_push_pull = cfg_q[rgsm_pkg::BIT_DRV_TYPE];
  wire trig_level = cfg_q[rgsm_pkg::BIT_TRIG_KIND];
  wire dir_out = cfg_q[rgsm_pkg::BIT_DIR];
  wire [3:0] src_sel = cfg_q[rgsm_pkg::SEL_MSB:rgsm_pkg::SEL_LSB];

  // ************************************************************
  // read path
  // ************************************************************
  // live level bit
  wire [7:0] cfg_rd = {cfg_q[rgsm_pkg::BIT_DRV_TYPE:rgsm_pkg::BIT_DIR],
    pin_level, cfg_q[rgsm_pkg::SEL_MSB:rgsm_pkg::SEL_LSB]};
  wire [7:0] nxt_rdata = hit_cfg ? cfg_rd :
    hit_tx ? tx_q : rgsm_pkg::RDATA_UNMAPPED;
  logic [7:0] rdata_ff;
  logic rvalid_ff;

  // ************************************************************
  // source mux
  // ************************************************************
  rgsm_pkg::rgsm_rpt_state_s st;
  assign st = i_rpt_state;
  logic src_val;
  always_comb begin
    case (rgsm_pkg::rgsm_src_e'(src_sel))
      rgsm_pkg::SRC_REMOTE_WAKE: src_val = st.remote_wake;
      rgsm_pkg::SRC_LSFS_DISC: src_val = st.lsfs_disc;
      rgsm_pkg::SRC_HS_UNSQUELCH: src_val = st.hs_unsquelch;
      rgsm_pkg::SRC_HS_DISC_SE1: src_val = st.hs_disc_se1;
      rgsm_pkg::SRC_UNCONFIGURED: src_val = st.unconfigured;
      rgsm_pkg::SRC_HOST_MODE: src_val = st.host_mode;
      rgsm_pkg::SRC_PERIPH_MODE: src_val = st.periph_mode;
      rgsm_pkg::SRC_CONNECTED: src_val = st.connected;
      rgsm_pkg::SRC_BUS_RESET: src_val = st.bus_reset && !st.l0;
      rgsm_pkg::SRC_L0: src_val = st.l0;
      rgsm_pkg::SRC_L1: src_val = st.l1;
      rgsm_pkg::SRC_L2: src_val = st.l2;
      rgsm_pkg::SRC_HS_TEST: src_val = st.hs_test;
      rgsm_pkg::SRC_FORCE_HIGH: src_val = 1'b1;
      rgsm_pkg::SRC_FORCE_LOW: src_val = 1'b0;
      rgsm_pkg::SRC_OVERVOLTAGE: src_val = st.overvoltage;
      default: src_val = 1'b0;
    endcase
  end

  // ************************************************************
  // pin driver
  // ************************************************************
  // open-drain drives low only
  wire drv_oe = drv_push_pull ? 1'b1 : !src_val;
  wire drv_out = drv_push_pull ? src_val : 1'b0;
  wire nxt_pin_oe = dir_out && drv_oe;
  wire nxt_pin_out = dir_out && drv_out;
  logic pin_oe_ff;
  logic pin_out_ff;

  // ************************************************************
  // interrupt request
  // ************************************************************
  // no edge until sync and delay flop hold the pin
  localparam int ARM_W = 3;
  logic [ARM_W-1:0] arm_ff;
  wire edge_armed = arm_ff[ARM_W-1];
  wire pin_edge = edge_armed && (pin_level ^ pin_level_d_ff);
  wire nxt_int = trig_level ? pin_level : pin_edge;
  logic int_ff;

  // ************************************************************
  // output flops
  // ************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rdata_ff <= rgsm_pkg::RDATA_UNMAPPED;
      rvalid_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      int_ff <= 1'b0;
      pin_level_d_ff <= 1'b0;
      arm_ff <= '0;
    end else begin
      rdata_ff <= i_reg_req.rd ? nxt_rdata : rdata_ff;
      rvalid_ff <= i_reg_req.rd;
      pin_oe_ff <= nxt_pin_oe;
      pin_out_ff <= nxt_pin_out;
      int_ff <= nxt_int;
      pin_level_d_ff <= pin_level;
      arm_ff <= {arm_ff[ARM_W-2:0], 1'b1};
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_reg_rvalid = rvalid_ff;
  assign o_pin_oe = pin_oe_ff;
  assign o_pin_out = pin_out_ff;
  assign o_int_req = int_ff;
  assign o_hs_termination_code =
    tx_q[rgsm_pkg::TERM_MSB:rgsm_pkg::TERM_LSB];
  assign o_hs_tx_slew_code = tx_q[rgsm_pkg::SLEW_MSB:rgsm_pkg::SLEW_LSB];
  assign o_hs_tx_amplitude_code =
    tx_q[rgsm_pkg::AMP_MSB:rgsm_pkg::AMP_LSB];

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  property p_open_drain;
    dir_out && !drv_push_pull |=> !o_pin_out && (o_pin_oe == !$past(src_val));
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin drive wrong");

  property p_push_pull;
    dir_out && drv_push_pull |=> o_pin_oe && (o_pin_out == $past(src_val));
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("push-pull pin drive wrong");

  property p_level_int;
    trig_level ##1 trig_level |-> o_int_req == $past(pin_level);
  endproperty
  a_level_int: assert property (p_level_int)
    else $error("level interrupt does not follow pin");

  property p_edge_int;
    !trig_level && edge_armed && $changed(pin_level) |=> o_int_req
      ##1 (!trig_level && $stable(pin_level)) [*1] |=> !o_int_req;
  endproperty
  a_edge_int: assert property (p_edge_int)
    else $error("edge interrupt not a single pulse");

  property p_input_dir;
    !dir_out |=> !o_pin_oe && !o_pin_out;
  endproperty
  a_input_dir: assert property (p_input_dir)
    else $error("pin driven while input");

  property p_level_read;
    i_reg_req.rd && hit_cfg |=> o_reg_rvalid
      && (o_reg_rdata[rgsm_pkg::BIT_IN_LEVEL] == $past(pin_level));
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("input level bit wrong");

  property p_level_nowrite;
    wr_cfg |=> cfg_q[rgsm_pkg::BIT_IN_LEVEL]
      == $past(i_reg_req.wdata[rgsm_pkg::BIT_IN_LEVEL])
      && cfg_rd[rgsm_pkg::BIT_IN_LEVEL] == pin_level;
  endproperty
  a_level_nowrite: assert property (p_level_nowrite)
    else $error("input level bit took a write");

  property p_force_high;
    dir_out && drv_push_pull && src_sel == rgsm_pkg::SRC_FORCE_HIGH
      |=> o_pin_out;
  endproperty
  a_force_high: assert property (p_force_high)
    else $error("forced high not driven");

  property p_force_low;
    dir_out && src_sel == rgsm_pkg::SRC_FORCE_LOW |=> o_pin_oe && !o_pin_out;
  endproperty
  a_force_low: assert property (p_force_low)
    else $error("forced low not driven");

  property p_reset_code;
    dir_out && drv_push_pull && src_sel == rgsm_pkg::SRC_BUS_RESET
      && st.l0 |=> !o_pin_out;
  endproperty
  a_reset_code: assert property (p_reset_code)
    else $error("reset code high in L0");

  property p_otp_load;
    i_otp_load |=> {o_hs_termination_code, o_hs_tx_slew_code,
      o_hs_tx_amplitude_code} == $past(i_otp_tx_adjust);
  endproperty
  a_otp_load: assert property (p_otp_load)
    else $error("factory default not loaded");

  property p_tx_write;
    i_reg_req.wr && hit_tx && !i_otp_load |=> o_hs_tx_slew_code
      == $past(i_reg_req.wdata[rgsm_pkg::SLEW_MSB:rgsm_pkg::SLEW_LSB])
      && o_hs_tx_amplitude_code
      == $past(i_reg_req.wdata[rgsm_pkg::AMP_MSB:rgsm_pkg::AMP_LSB])
      && o_hs_termination_code
      == $past(i_reg_req.wdata[rgsm_pkg::TERM_MSB:rgsm_pkg::TERM_LSB]);
  endproperty
  a_tx_write: assert property (p_tx_write)
    else $error("tx adjust write lost");

  property p_tx_reset;
    $fell(i_srst) |-> tx_q == rgsm_pkg::RST_TX_ADJ;
  endproperty
  a_tx_reset: assert property (@(posedge i_ref_clk) p_tx_reset)
    else $error("tx adjust reset value wrong");

  property p_no_false_edge;
    !edge_armed && !trig_level |=> !o_int_req;
  endproperty
  a_no_false_edge: assert property (p_no_false_edge)
    else $error("edge interrupt before pin sampled");

  property p_tx_hold;
    !ld_tx |=> $stable(tx_q);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx adjust changed without load");

  c_otp_load: cover property (i_otp_load);
  c_pp_high: cover property (dir_out && drv_push_pull ##1 o_pin_out);
  c_edge: cover property (!trig_level ##1 o_int_req);
  c_od_release: cover property (dir_out && !drv_push_pull && src_val);
endmodule // rgsm_top
`default_nettype wire

// ---- verif/rgsm_pin_partner.sv ----
// rgsm_pin_partner: system logic watching general pin one
// assumes: pin has a pull-up, bench sets the far side drive
`timescale 1ns/1ns
`default_nettype none
module rgsm_pin_partner (
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  input wire logic i_ext_drive,
  input wire logic i_ext_level,
  output logic o_pin_level
);
  // ************************************************************
  // wire resolution
  // ************************************************************
  // released pin pulled up
  assign o_pin_level = i_pin_oe ? i_pin_out :
                       (i_ext_drive ? i_ext_level : 1'b1);
endmodule // rgsm_pin_partner
`default_nettype wire

// ---- verif/tb_repeater_general_pin_one_status_mux.sv ----
// tb_repeater_general_pin_one_status_mux: self-checking bench of rgsm_top
// assumes: rgsm_pkg compiled first, partner model on the pin
`timescale 1ns/1ns
`default_nettype none
module tb_repeater_general_pin_one_status_mux;
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  rgsm_pkg::rgsm_reg_req_s req = '0;
  rgsm_pkg::rgsm_rpt_state_s st = '0;
  logic otp_ld = 1'b0;
  logic [7:0] otp_d = 8'h00;
  logic ext_drv = 1'b1;
  logic ext_lvl = 1'b0;
  logic pin_lvl;
  logic [7:0] rdata;
  logic rvalid, pin_out, pin_oe, int_req;
  logic [1:0] term, slew;
  logic [3:0] amp;
  int bad_count = 0;
  int checks_done = 0;
  always #50 i_ref_clk = ~i_ref_clk;
  // ************************************************************
  // instances
  // ************************************************************
  rgsm_top uut (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
    .i_reg_req(req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_rpt_state(st), .i_otp_load(otp_ld), .i_otp_tx_adjust(otp_d),
    .i_pin_in(pin_lvl), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .o_int_req(int_req), .o_hs_termination_code(term),
    .o_hs_tx_slew_code(slew), .o_hs_tx_amplitude_code(amp));
  rgsm_pin_partner u_far (.i_pin_out(pin_out), .i_pin_oe(pin_oe),
    .i_ext_drive(ext_drv), .i_ext_level(ext_lvl),
    .o_pin_level(pin_lvl));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic end_sim;
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string msg);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_ref_clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_ref_clk);
    req <= '0;
    #1;
    chk({7'h00, rvalid}, 8'h01, "read answer missing");
    chk(rdata, exp, "read data");
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rd(8'h40, 8'h00);
    rd(8'h70, 8'h7c);
    chk({6'h00, term}, 8'h01, "termination after reset");
    chk({6'h00, slew}, 8'h03, "slew after reset");
    chk({4'h0, amp}, 8'h0c, "amplitude after reset");
    rd(8'h41, 8'h00);
  endtask
  task automatic t_txadj;
    wr(8'h70, 8'h93);
    tick(1);
    chk({6'h00, term}, 8'h02, "termination code");
    chk({6'h00, slew}, 8'h01, "slew code");
    chk({4'h0, amp}, 8'h03, "amplitude code");
    wr(8'h71, 8'hff);
    rd(8'h70, 8'h93);
    @(posedge i_ref_clk);
    otp_ld <= 1'b1;
    otp_d <= 8'h5a;
    req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h70, wdata: 8'ha5};
    @(posedge i_ref_clk);
    otp_ld <= 1'b0;
    req <= '0;
    rd(8'h70, 8'h5a);
  endtask
  task automatic t_mux;
    logic [13:0] one;
    for (int c = 0; c < 16; c++) begin
      one = 14'h0001 << ((c == 15) ? 0 : 13 - c);
      wr(8'h40, {4'ha, c[3:0]});
      @(posedge i_ref_clk);
      st <= (c == 13) ? '0 : rgsm_pkg::rgsm_rpt_state_s'(~one);
      tick(3);
      chk({7'h00, pin_oe}, 8'h01, "push-pull drive enable");
      if (c == 13 || c == 14) begin
        chk({7'h00, pin_out}, {7'h00, c == 13}, "forced level");
      end else begin
        chk({7'h00, pin_out}, 8'h00, "source inactive");
        @(posedge i_ref_clk);
        st <= rgsm_pkg::rgsm_rpt_state_s'(one);
        tick(3);
        chk({7'h00, pin_out}, 8'h01, "source active");
      end
    end
    wr(8'h40, 8'ha8);
    @(posedge i_ref_clk);
    st <= rgsm_pkg::rgsm_rpt_state_s'(14'h0030);
    tick(3);
    chk({7'h00, pin_out}, 8'h00, "reset code low in L0");
  endtask
  task automatic t_drain;
    wr(8'h40, 8'h2d);
    tick(3);
    chk({7'h00, pin_oe}, 8'h00, "open drain high released");
    rd(8'h40, 8'h3d);
    wr(8'h40, 8'h2e);
    tick(3);
    chk({6'h00, pin_oe, pin_out}, 8'h02, "open drain low");
    rd(8'h40, 8'h2e);
  endtask
  task automatic t_input;
    @(posedge i_ref_clk);
    ext_drv <= 1'b1;
    ext_lvl <= 1'b1;
    wr(8'h40, 8'h8d);
    tick(3);
    chk({7'h00, pin_oe}, 8'h00, "input pin driven");
    rd(8'h40, 8'h9d);
    @(posedge i_ref_clk);
    ext_lvl <= 1'b0;
    wr(8'h40, 8'h1d);
    tick(3);
    rd(8'h40, 8'h0d);
  endtask
  task automatic t_int;
    int n;
    wr(8'h40, 8'h40);
    @(posedge i_ref_clk);
    ext_lvl <= 1'b1;
    tick(4);
    chk({7'h00, int_req}, 8'h01, "level interrupt high");
    @(posedge i_ref_clk);
    ext_lvl <= 1'b0;
    tick(4);
    chk({7'h00, int_req}, 8'h00, "level interrupt low");
    wr(8'h40, 8'h00);
    tick(4);
    @(posedge i_ref_clk);
    ext_lvl <= 1'b1;
    n = 0;
    repeat (8) begin
      @(posedge i_ref_clk);
      #1;
      if (int_req === 1'b1) n++;
    end
    chk(n[7:0], 8'h01, "edge interrupt pulse count");
    @(posedge i_ref_clk);
    ext_lvl <= 1'b0;
    n = 0;
    repeat (8) begin
      @(posedge i_ref_clk);
      #1;
      if (int_req === 1'b1) n++;
    end
    chk(n[7:0], 8'h01, "falling edge pulse count");
  endtask
  task automatic t_midreset;
    int n;
    @(posedge i_ref_clk);
    ext_drv <= 1'b0;
    tick(4);
    @(posedge i_ref_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    n = 0;
    repeat (8) begin
      @(posedge i_ref_clk);
      #1;
      if (int_req === 1'b1) n++;
    end
    chk(n[7:0], 8'h00, "false edge after reset");
    rd(8'h40, 8'h10);
    rd(8'h70, 8'h7c);
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    #1000000;
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    tick(2);
    t_reset();
    t_txadj();
    @(posedge i_ref_clk);
    ext_drv <= 1'b0;
    t_mux();
    t_drain();
    t_input();
    t_int();
    t_midreset();
    end_sim();
  end
endmodule // tb_repeater_general_pin_one_status_mux
`default_nettype wire
